// ===== src/pcs_config_target.sv
// pcs_config_target: configuration-space target with axi4-lite access
//
// Overview of operation
// RULE_01 - claim only type 0 requests to function 0; stay silent otherwise
// RULE_02 - decode the three-bit function field; only function 0 exists
// RULE_03 - decode 256 bytes; first 64 standard header, rest device specific
// RULE_04 - with select asserted, answer with devsel and decode offset, lanes
// RULE_05 - command bits gate target, master and parity reporting
// RULE_06 - decode the port window at the programmed port base
// RULE_07 - decode the mapped window at the programmed mapped base
// RULE_08 - option rom base and size come from the rom window register
// RULE_09 - hold line length and present it to the burst logic
// RULE_10 - latency timer from the hold limit bounds bus ownership
// RULE_11 - keep a writable interrupt routing byte
// RULE_12 - media and buffer setup register reachable in port window 3
// RULE_13 - unimplemented offsets read zero and drop writes
`timescale 1ns/10ps
`default_nettype none
module pcs_config_target #(
   parameter logic [31:0] DEVICE_ID   = 32'h0001_0001, // arbitrary value
   parameter logic [7:0]  REVISION_ID = 8'h01          // arbitrary value
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        idsel,
   output logic             devsel,
   input  wire logic        tgt_valid,
   input  wire logic        tgt_io,
   input  wire logic        tgt_we,
   input  wire logic [31:0] tgt_addr,
   input  wire logic [31:0] tgt_wdata,
   input  wire logic [2:0]  tgt_window,
   output logic             io_claim,
   output logic             mem_claim,
   output logic             rom_claim,
   output logic [31:0]      tgt_rdata,
   output logic [31:0]      media_and_buffer_setup,
   output logic             master_en,
   output logic             parity_report_en,
   output logic             serr_report_en,
   output logic [7:0]       host_line_length,
   output logic [7:0]       irq_routing,
   input  wire logic        master_owns,
   output logic             hold_expired
);
   logic        idsel_meta;
   logic        idsel_sync;
   logic        aw_full;
   logic        w_full;
   logic [31:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic [31:0] bus_cycle_enables;
   logic [31:0] line_word;
   logic [31:0] port_window_base;
   logic [31:0] mapped_window_base;
   logic [31:0] option_rom_window;
   logic [31:0] irq_word;
   logic [31:0] next_rdata;
   logic        do_write;
   logic        wr_claim;
   logic        rd_claim;
   logic        io_hit;
   logic        mem_hit;
   logic        rom_hit;
   logic        media_sel;
   pcs_pkg::pcs_cfg_addr_t wr_cfg;
   pcs_pkg::pcs_cfg_addr_t rd_cfg;
   pcs_pkg::pcs_tgt_req_t  req;

   // byte-lane merge limited to the writable bits of one word
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0]  strb,
                                         input logic [31:0] mask);
      logic [31:0] lanes;
      lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      return (old & ~(lanes & mask)) | (data & lanes & mask);
   endfunction

   // claim decision shared by reads and writes
   function automatic logic claims(input logic sel,
                                   input logic [31:0] addr);
      pcs_pkg::pcs_cfg_addr_t a;
      a = addr[pcs_pkg::ADDR_TOP:0];
      return sel && !a.type1 && (a.func == pcs_pkg::OWN_FUNC); // RULE_01 RULE_02
   endfunction

   // the select pin is asynchronous to aclk
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         idsel_meta <= 1'b0;
         idsel_sync <= 1'b0;
      end else begin
         idsel_meta <= idsel;
         idsel_sync <= idsel_meta;
      end
   end

   assign wr_cfg   = aw_addr[pcs_pkg::ADDR_TOP:0];
   assign rd_cfg   = s_axi_araddr[pcs_pkg::ADDR_TOP:0];
   assign do_write = aw_full && w_full && !s_axi_bvalid;
   assign wr_claim = claims(idsel_sync, aw_addr); // RULE_04
   assign rd_claim = claims(idsel_sync, s_axi_araddr); // RULE_04

   // write address and data are taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         aw_addr <= 32'h0000_0000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_full <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
         aw_full <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_full <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (do_write) begin
         w_full <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !aw_full && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !w_full && !(s_axi_wvalid && s_axi_wready);
      end
   end

   // an unclaimed request still gets an answer so the bus never hangs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= pcs_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_claim ? pcs_pkg::RESP_OKAY : pcs_pkg::RESP_DECERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // header registers, each limited to its writable bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bus_cycle_enables <= 32'h0000_0000;
      end else if (do_write && wr_claim && wr_cfg.ofs == pcs_pkg::OFS_CMD) begin
         bus_cycle_enables <= merge(bus_cycle_enables, w_data, w_strb,
                                    pcs_pkg::MASK_CMD); // RULE_05
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line_word <= 32'h0000_0000;
      end else if (do_write && wr_claim && wr_cfg.ofs == pcs_pkg::OFS_LINE) begin
         line_word <= merge(line_word, w_data, w_strb, pcs_pkg::MASK_LINE); // RULE_09 RULE_10
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port_window_base <= 32'h0000_0000;
      end else if (do_write && wr_claim && wr_cfg.ofs == pcs_pkg::OFS_IO_BAR) begin
         port_window_base <= merge(port_window_base, w_data, w_strb,
                                   pcs_pkg::MASK_IO_BAR); // RULE_06
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mapped_window_base <= 32'h0000_0000;
      end else if (do_write && wr_claim && wr_cfg.ofs == pcs_pkg::OFS_MEM_BAR) begin
         mapped_window_base <= merge(mapped_window_base, w_data, w_strb,
                                     pcs_pkg::MASK_MEM_BAR); // RULE_07
      end
   end

   // size is found by writing ones and reading back the fixed low zeros
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         option_rom_window <= 32'h0000_0000;
      end else if (do_write && wr_claim && wr_cfg.ofs == pcs_pkg::OFS_ROM) begin
         option_rom_window <= merge(option_rom_window, w_data, w_strb,
                                    pcs_pkg::MASK_ROM); // RULE_08
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_word <= 32'h0000_0000;
      end else if (do_write && wr_claim && wr_cfg.ofs == pcs_pkg::OFS_IRQ) begin
         irq_word <= merge(irq_word, w_data, w_strb, pcs_pkg::MASK_IRQ); // RULE_11
      end
   end

   // read data; every other offset in the 256 bytes reads zero
   always_comb begin
      next_rdata = 32'h0000_0000; // RULE_13
      case (rd_cfg.ofs) // RULE_03
         pcs_pkg::OFS_ID:      next_rdata = DEVICE_ID;
         pcs_pkg::OFS_CMD:     next_rdata = pcs_pkg::RD_STATUS | bus_cycle_enables;
         pcs_pkg::OFS_CLASS:   next_rdata = {24'h02_0000, REVISION_ID};
         pcs_pkg::OFS_LINE:    next_rdata = line_word;
         pcs_pkg::OFS_IO_BAR:  next_rdata = port_window_base | pcs_pkg::RD_IO_BAR;
         pcs_pkg::OFS_MEM_BAR: next_rdata = mapped_window_base;
         pcs_pkg::OFS_ROM:     next_rdata = option_rom_window;
         pcs_pkg::OFS_IRQ:     next_rdata = irq_word | pcs_pkg::RD_IRQ_PIN;
         default:              next_rdata = 32'h0000_0000;
      endcase
      if (!rd_claim) begin
         next_rdata = 32'h0000_0000;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= pcs_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= rd_claim ? pcs_pkg::RESP_OKAY : pcs_pkg::RESP_DECERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // one-cycle device select for each claimed access
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         devsel <= 1'b0;
      end else begin
         devsel <= (do_write && wr_claim)
                   || (s_axi_arvalid && s_axi_arready && rd_claim); // RULE_04
      end
   end

   // target side: port, mapped and rom windows
   assign req = '{addr: tgt_addr, wdata: tgt_wdata, we: tgt_we,
                  io: tgt_io, window: tgt_window};

   pcs_window_match #(.SPAN(pcs_pkg::IO_SPAN)) u_io_match (
      .addr   (req.addr),
      .base   (port_window_base),
      .enable (req.io && bus_cycle_enables[pcs_pkg::CMD_IO]), // RULE_05 RULE_06
      .hit    (io_hit)
   );

   pcs_window_match #(.SPAN(pcs_pkg::MEM_SPAN)) u_mem_match (
      .addr   (req.addr),
      .base   (mapped_window_base),
      .enable (!req.io && bus_cycle_enables[pcs_pkg::CMD_MEM]), // RULE_05 RULE_07
      .hit    (mem_hit)
   );

   pcs_window_match #(.SPAN(pcs_pkg::ROM_SPAN)) u_rom_match (
      .addr   (req.addr),
      .base   (option_rom_window),
      .enable (!req.io && !req.we && bus_cycle_enables[pcs_pkg::CMD_MEM]
               && option_rom_window[pcs_pkg::ROM_EN]), // RULE_08
      .hit    (rom_hit)
   );

   // rom wins over the mapped window only if software overlaps them
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         io_claim  <= 1'b0;
         mem_claim <= 1'b0;
         rom_claim <= 1'b0;
      end else begin
         io_claim  <= tgt_valid && io_hit;
         mem_claim <= tgt_valid && mem_hit && !rom_hit;
         rom_claim <= tgt_valid && rom_hit;
      end
   end

   assign media_sel = io_hit && (req.window == pcs_pkg::MEDIA_WINDOW)
                      && (req.addr[pcs_pkg::IO_SPAN-1:0] == pcs_pkg::MEDIA_OFS);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         media_and_buffer_setup <= pcs_pkg::RST_MEDIA;
      end else if (tgt_valid && req.we && media_sel) begin
         media_and_buffer_setup <= req.wdata & pcs_pkg::MASK_MEDIA; // RULE_12
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tgt_rdata <= 32'h0000_0000;
      end else if (tgt_valid && !req.we) begin
         tgt_rdata <= media_sel ? media_and_buffer_setup : 32'h0000_0000; // RULE_12
      end
   end

   // command and header fields for the rest of the adapter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         master_en        <= 1'b0;
         parity_report_en <= 1'b0;
         serr_report_en   <= 1'b0;
         host_line_length <= 8'h00;
         irq_routing      <= 8'h00;
      end else begin
         master_en        <= bus_cycle_enables[pcs_pkg::CMD_MASTER]; // RULE_05
         parity_report_en <= bus_cycle_enables[pcs_pkg::CMD_PARITY]; // RULE_05
         serr_report_en   <= bus_cycle_enables[pcs_pkg::CMD_SERR];
         host_line_length <= line_word[7:0]; // RULE_09
         irq_routing      <= irq_word[7:0]; // RULE_11
      end
   end

   // ownership only counts while mastering is enabled
   pcs_hold_timer u_hold (
      .aclk    (aclk),
      .aresetn (aresetn),
      .limit   (line_word[15:8]),
      .owns    (master_owns && bus_cycle_enables[pcs_pkg::CMD_MASTER]), // RULE_10
      .expired (hold_expired)
   );
endmodule // pcs_config_target
`default_nettype wire

// ===== shared/pcs_pkg.sv
// pcs_pkg: shared constants and types of the configuration target
package pcs_pkg;
   // configuration request address: type, function, register offset
   typedef struct packed {
      logic       type1;
      logic [2:0] func;
      logic [7:0] ofs;
   } pcs_cfg_addr_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic        we;
      logic        io;
      logic [2:0]  window;
   } pcs_tgt_req_t;

   localparam logic [2:0]  OWN_FUNC     = 3'h0;
   localparam logic [7:0]  HDR_END      = 8'h40;
   localparam logic [3:0]  ADDR_TOP     = 4'hB;

   localparam logic [7:0]  OFS_ID       = 8'h00;
   localparam logic [7:0]  OFS_CMD      = 8'h04;
   localparam logic [7:0]  OFS_CLASS    = 8'h08;
   localparam logic [7:0]  OFS_LINE     = 8'h0C;
   localparam logic [7:0]  OFS_IO_BAR   = 8'h10;
   localparam logic [7:0]  OFS_MEM_BAR  = 8'h14;
   localparam logic [7:0]  OFS_ROM      = 8'h30;
   localparam logic [7:0]  OFS_IRQ      = 8'h3C;

   localparam logic [31:0] MASK_CMD     = 32'h0000_0147;
   localparam logic [31:0] MASK_LINE    = 32'h0000_FFFF;
   localparam logic [31:0] MASK_IO_BAR  = 32'hFFFF_FF80;
   localparam logic [31:0] MASK_MEM_BAR = 32'hFFFF_FF80;
   localparam logic [31:0] MASK_ROM     = 32'hFFFE_0001;
   localparam logic [31:0] MASK_IRQ     = 32'h0000_00FF;
   localparam logic [31:0] MASK_MEDIA   = 32'hFFFF_FFFF;

   localparam logic [31:0] RD_STATUS    = 32'h0200_0000;
   localparam logic [31:0] RD_IO_BAR    = 32'h0000_0001;
   localparam logic [31:0] RD_IRQ_PIN   = 32'h0000_0100;
   localparam logic [31:0] RST_MEDIA    = 32'h0000_0000;

   localparam int          IO_SPAN      = 7;
   localparam int          MEM_SPAN     = 7;
   localparam int          ROM_SPAN     = 17;

   localparam int          CMD_IO       = 0;
   localparam int          CMD_MEM      = 1;
   localparam int          CMD_MASTER   = 2;
   localparam int          CMD_PARITY   = 6;
   localparam int          CMD_SERR     = 8;
   localparam int          ROM_EN       = 0;

   localparam logic [2:0]  MEDIA_WINDOW = 3'h3;
   localparam logic [6:0]  MEDIA_OFS    = 7'h00;

   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_DECERR  = 2'h3;
endpackage

// ===== src/pcs_window_match.sv
// pcs_window_match: base address compare for one decoded window
`timescale 1ns/10ps
`default_nettype none
module pcs_window_match #(
   parameter int SPAN = 7
) (
   input  wire logic [31:0] addr,
   input  wire logic [31:0] base,
   input  wire logic        enable,
   output logic             hit
);
   // the low span bits are the offset inside the window
   assign hit = enable && (addr[31:SPAN] == base[31:SPAN]);
endmodule // pcs_window_match
`default_nettype wire

// ===== src/pcs_hold_timer.sv
// pcs_hold_timer: bus ownership limit counter
`timescale 1ns/10ps
`default_nettype none
module pcs_hold_timer (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [7:0] limit,
   input  wire logic       owns,
   output logic            expired
);
   logic [7:0] count;

   // reloaded every cycle without ownership, so each fresh ownership starts from the current limit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count <= 8'h00;
      end else if (!owns) begin
         count <= limit;
      end else if (count != 8'h00) begin
         count <= count - 8'h01;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         expired <= 1'b0;
      end else begin
         expired <= owns && (count == 8'h00);
      end
   end
endmodule // pcs_hold_timer
`default_nettype wire

// ===== testbench/pcs_config_monitor.sv
// pcs_config_monitor: port-level assertions of the configuration target
`timescale 1ns/10ps
`default_nettype none
module pcs_config_monitor (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        devsel,
   input wire logic        tgt_valid,
   input wire logic        tgt_io,
   input wire logic        tgt_we,
   input wire logic [2:0]  tgt_window,
   input wire logic        io_claim,
   input wire logic        mem_claim,
   input wire logic [31:0] media_and_buffer_setup,
   input wire logic        master_owns,
   input wire logic        hold_expired
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_devsel_pulse;
      devsel |=> !devsel;
   endproperty
   a_devsel_pulse: assert property (p_devsel_pulse)
      else $error("devsel held over one cycle");
   property p_okay_claims;
      $rose(s_axi_bvalid) && s_axi_bresp == pcs_pkg::RESP_OKAY |-> devsel;
   endproperty
   a_okay_claims: assert property (p_okay_claims)
      else $error("okay write without devsel");
   property p_decerr_silent;
      $rose(s_axi_bvalid) && s_axi_bresp == pcs_pkg::RESP_DECERR |-> !devsel;
   endproperty
   a_decerr_silent: assert property (p_decerr_silent)
      else $error("devsel on an unclaimed write");
   property p_decerr_zero;
      s_axi_rvalid && s_axi_rresp == pcs_pkg::RESP_DECERR |-> s_axi_rdata == 32'h0;
   endproperty
   a_decerr_zero: assert property (p_decerr_zero)
      else $error("unclaimed read returned data");
   property p_io_cause;
      io_claim |-> $past(tgt_valid && tgt_io);
   endproperty
   a_io_cause: assert property (p_io_cause)
      else $error("port claim unrequested");
   property p_mem_cause;
      mem_claim |-> $past(tgt_valid && !tgt_io);
   endproperty
   a_mem_cause: assert property (p_mem_cause)
      else $error("mapped claim unrequested");
   property p_media_cause;
      !$stable(media_and_buffer_setup)
         |-> $past(tgt_valid && tgt_we && tgt_io && tgt_window == pcs_pkg::MEDIA_WINDOW);
   endproperty
   a_media_cause: assert property (p_media_cause)
      else $error("media setup changed unasked");
   property p_expired_owns;
      hold_expired |-> $past(master_owns);
   endproperty
   a_expired_owns: assert property (p_expired_owns)
      else $error("expiry without ownership");

   c_io: cover property (io_claim);
   c_mem: cover property (mem_claim);
   c_expired: cover property (hold_expired);
endmodule // pcs_config_monitor

bind pcs_config_target pcs_config_monitor u_mon (.*);
`default_nettype wire

// ===== testbench/pcs_host_model.sv
// pcs_host_model: host bridge issuing configuration cycles over axi4-lite
`timescale 1ns/10ps
`default_nettype none
module pcs_host_model (
   input  wire logic        aclk,
   output logic [31:0]      s_axi_awaddr,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic [31:0]      s_axi_wdata,
   output logic [3:0]       s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   output logic [31:0]      s_axi_araddr,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready,
   output logic             idsel
);
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready, idsel} = '0;
   end

   // select leads so the target's two-flop synchroniser has caught it
   task automatic open_cycle(input logic sel);
      @(posedge aclk);
      idsel <= sel;
      repeat (3) @(posedge aclk);
   endtask

   task automatic cfg_wr(input logic sel, input logic [31:0] a, d, input logic [3:0] s,
                         output logic [1:0] r);
      logic done;
      done = 1'h0;
      open_cycle(sel);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'h1;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= s;
      s_axi_wvalid  <= 1'h1;
      s_axi_bready  <= 1'h1;
      while (!done) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awvalid <= 1'h0;
            s_axi_awaddr  <= ~a;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wvalid <= 1'h0;
            s_axi_wdata  <= ~d;
         end
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'h0;
            idsel        <= 1'h0;
            done = 1'h1;
         end
      end
   endtask

   task automatic cfg_rd(input logic sel, input logic [31:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      logic done;
      done = 1'h0;
      open_cycle(sel);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready  <= 1'h1;
      while (!done) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arvalid <= 1'h0;
            s_axi_araddr  <= ~a;
         end
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'h0;
            idsel        <= 1'h0;
            done = 1'h1;
         end
      end
   endtask
endmodule // pcs_host_model
`default_nettype wire

// ===== testbench/pci_config_space_target_test.sv
// pci_config_space_target_test: self-checking bench of the configuration target
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
   $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module pci_config_space_target_test;
   localparam logic [31:0] DEV_ID = 32'h0002_0003; // arbitrary value
   localparam logic [1:0]  OK     = pcs_pkg::RESP_OKAY;
   localparam logic [1:0]  DE     = pcs_pkg::RESP_DECERR;
   localparam logic [7:0]  T_OFS [8] = '{8'h04, 8'h0C, 8'h10, 8'h14, 8'h30, 8'h3C, 8'h40, 8'hFC};
   localparam logic [31:0] T_EXP [8] = '{pcs_pkg::MASK_CMD | pcs_pkg::RD_STATUS,
      pcs_pkg::MASK_LINE, pcs_pkg::MASK_IO_BAR | pcs_pkg::RD_IO_BAR, pcs_pkg::MASK_MEM_BAR,
      pcs_pkg::MASK_ROM, pcs_pkg::MASK_IRQ | pcs_pkg::RD_IRQ_PIN, 32'h0, 32'h0};
   logic        aclk, aresetn, idsel, devsel, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, tgt_valid, tgt_io, tgt_we, io_claim, mem_claim;
   logic        rom_claim, master_en, parity_report_en, serr_report_en, master_owns;
   logic        hold_expired;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [2:0]  tgt_window;
   logic [3:0]  s_axi_wstrb;
   logic [4:0]  k;
   logic [7:0]  host_line_length, irq_routing;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, tgt_addr, tgt_wdata;
   logic [31:0] tgt_rdata, media_and_buffer_setup;
   int          n_fail, checks_done, cycles, n;

   pcs_config_target #(.DEVICE_ID(DEV_ID)) dut (.*);
   pcs_host_model host (.*);

   initial begin
      aclk = 1'h0;
      forever #2 aclk = ~aclk;
   end

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // a hung handshake must not stall the run
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         give_verdict();
      end
   end

   task automatic wr(input logic sel, input logic [31:0] a, d, input logic [3:0] s,
                     input logic [1:0] er);
      logic [1:0] r;
      host.cfg_wr(sel, a, d, s, r);
      `CHK(r, er)
   endtask

   task automatic rd(input logic sel, input logic [31:0] a, ed, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      host.cfg_rd(sel, a, d, r);
      `CHK(r, er)
      `CHK(d, ed)
   endtask

   // one-cycle target request; claims checked just after the next edge
   task automatic tgt(input logic io, we, input logic [31:0] a, input logic [2:0] exp_claim,
                      input logic [2:0] w = 3'h0, input logic [31:0] d = 32'h0);
      @(posedge aclk);
      tgt_valid  <= 1'h1;
      tgt_io     <= io;
      tgt_we     <= we;
      tgt_addr   <= a;
      tgt_wdata  <= d;
      tgt_window <= w;
      @(posedge aclk);
      tgt_valid <= 1'h0;
      #1;
      `CHK({rom_claim, mem_claim, io_claim}, exp_claim)
   endtask

   initial begin
      {aresetn, tgt_valid, tgt_io, tgt_we, tgt_addr, tgt_wdata, tgt_window, master_owns} = '0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (2) @(posedge aclk);
      rd(1'h1, 32'h04, pcs_pkg::RD_STATUS, OK);
      `CHK({master_en, parity_report_en, serr_report_en}, 3'h0)
      rd(1'h1, 32'h00, DEV_ID, OK);
      $display("test reset done");
      for (k = 0; k < 16; k++) begin
         wr(1'h1, {20'h0, k[3:0], 8'h3C}, {24'h0, 4'h1, k[3:0]}, 4'hF, k == 0 ? OK : DE);
         rd(1'h1, {20'h0, k[3:0], 8'h3C}, k == 0 ? 32'h110 : 32'h0, k == 0 ? OK : DE);
      end
      wr(1'h0, 32'h3C, 32'h55, 4'hF, DE);
      rd(1'h0, 32'h3C, 32'h0, DE);
      `CHK(irq_routing, 8'h10)
      $display("test claims done");
      for (k = 0; k < 8; k++) begin
         wr(1'h1, {24'h0, T_OFS[k]}, 32'hFFFF_FFFF, 4'hF, OK);
         rd(1'h1, {24'h0, T_OFS[k]}, T_EXP[k], OK);
      end
      `CHK({master_en, parity_report_en, serr_report_en}, 3'h7)
      `CHK({host_line_length, irq_routing}, 16'hFFFF)
      wr(1'h1, 32'h0C, 32'h0000_0512, 4'h1, OK);
      wr(1'h1, 32'h0C, 32'h0000_0500, 4'h2, OK);
      rd(1'h1, 32'h0C, 32'h0000_0512, OK);
      `CHK(host_line_length, 8'h12)
      $display("test registers done");
      wr(1'h1, 32'h10, 32'h0000_1000, 4'hF, OK);
      wr(1'h1, 32'h14, 32'h0002_0000, 4'hF, OK);
      wr(1'h1, 32'h30, 32'h0004_0001, 4'hF, OK);
      wr(1'h1, 32'h04, 32'h0000_0003, 4'hF, OK);
      tgt(1'h1, 1'h0, 32'h1004, 3'h1);
      `CHK(master_en, 1'h0)
      tgt(1'h1, 1'h0, 32'h1080, 3'h0);
      tgt(1'h0, 1'h0, 32'h2_0010, 3'h2);
      tgt(1'h0, 1'h0, 32'h4_0100, 3'h4);
      tgt(1'h0, 1'h0, 32'h6_0100, 3'h0);
      tgt(1'h1, 1'h1, 32'h1000, 3'h1, 3'h3, 32'hCAFE_F00D);
      tgt(1'h1, 1'h1, 32'h1000, 3'h1, 3'h2, 32'h1);
      tgt(1'h1, 1'h1, 32'h1004, 3'h1, 3'h3, 32'h1);
      `CHK(media_and_buffer_setup, 32'hCAFE_F00D)
      tgt(1'h1, 1'h0, 32'h1000, 3'h1, 3'h3);
      `CHK(tgt_rdata, 32'hCAFE_F00D)
      wr(1'h1, 32'h30, 32'h0004_0000, 4'hF, OK);
      tgt(1'h0, 1'h0, 32'h4_0100, 3'h0);
      wr(1'h1, 32'h04, 32'h0000_0004, 4'hF, OK);
      tgt(1'h1, 1'h0, 32'h1004, 3'h0);
      tgt(1'h0, 1'h0, 32'h2_0010, 3'h0);
      $display("test windows done");
      @(posedge aclk);
      master_owns <= 1'h1;
      for (n = 1; n < 20 && hold_expired !== 1'h1; n++) begin
         @(posedge aclk);
         #1;
      end
      `CHK(n inside {[6:8]}, 1'h1)
      @(posedge aclk);
      master_owns <= 1'h0;
      repeat (2) @(posedge aclk);
      #1;
      `CHK(hold_expired, 1'h0)
      $display("test hold timer done");
      give_verdict();
   end
endmodule // pci_config_space_target_test
`default_nettype wire
